//--- rtl/sjf_tx.sv
`timescale 1ns/10ps
// Operation
// - octets in are 8 bits, code-groups 10
// - encoder also makes the twelve control code-groups
// - comma is 0011111 or 1100000 leading
// - only K28.1, K28.5, K28.7 mark alignment
// - one sample per frame, two code-groups
// - scramble samples with 1+x^14+x^15 when enabled
// - receiver descrambler discards first sample
// - after sync, swap last code-group for K28.7 when its octet repeats the previous frame's last octet
// - receiver checks K28.7 position, restores value
// - idle set: K28.5 then D16.2 or D5.6
// - send K28.5 preamble while sync requested
// - request withdrawn; preamble ends at frame end
// - first data code-group after preamble starts frame
// - disparity judged per 6-bit and 4-bit sub-block
// - more ones positive, more zeros negative
// - pick code-group form by running disparity
// - sample leaves pipeline nine sample clocks later
// - capture on rising edge where plus exceeds minus
// - sync request low two sample clocks starts sync
// - scramble before 8b/10b coding
// - without idle mode, preamble is all K28.5
// - frame monitor enable high turns on K28.7 swap
module sjf_tx
  import sjf_pkg::*;
#(
  parameter int LAT = SJF_PIPE_LAT
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rstn,
  // sample clock and sample pins
  input wire logic                 sample_clock_p,
  input wire logic                 sample_clock_n,
  input wire logic [SJF_SMP_W-1:0] sample_in,
  // mode pins
  input wire logic                 scramble_enable,
  input wire logic                 frame_monitor_enable,
  input wire logic                 idle_sync_select,
  // status
  output logic                     sync_active,
  output logic                     link_synced,
  // link
  sjf_link_if.dev                  link
);

  localparam logic [1:0] LOW_TRIG = 2'(SJF_SYNC_MIN - 1);
  localparam logic [1:0] LOW_MAX  = 2'(SJF_SYNC_MIN);

  logic [SJF_NPIN-1:0]  pin_m_q;
  logic [SJF_NPIN-1:0]  pin_s_q;
  logic [SJF_SMP_W-1:0] din_m_q;
  logic [SJF_SMP_W-1:0] din_s_q;
  logic                 sclk_hi_q;
  logic                 sclk_hi;
  logic                 edge_s;
  logic                 sync_low;
  logic [SJF_SMP_W-1:0] pipe_q [LAT];
  logic [1:0]           low_q;
  sjf_tx_st_e           st_q;
  logic                 synced_q;
  logic                 pre_frame;
  logic [14:0]          scr_q;
  logic [30:0]          scr_w;
  logic [SJF_SMP_W-1:0] word;
  logic [7:0]           prev_lo_q;
  logic                 fam_hit;
  logic                 second_q;
  logic                 idle2_q;
  logic                 k2_q;
  logic [7:0]           oct2_q;
  logic                 rd_q;
  logic [7:0]           enc_oct;
  logic                 enc_k;
  logic                 emit;
  logic [10:0]          enc_r;
  logic [SJF_CG_W-1:0]  cg_q;
  logic                 cgv_q;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_m_q <= SJF_PIN_RST;
      pin_s_q <= SJF_PIN_RST;
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      pin_m_q <= {sample_clock_p, sample_clock_n, link.sync_n,
                  frame_monitor_enable, scramble_enable,
                  idle_sync_select};
      pin_s_q <= pin_m_q;
      din_m_q <= sample_in;
      din_s_q <= din_m_q;
    end
  end

  assign sclk_hi  = pin_s_q[SJF_P_SCP] & ~pin_s_q[SJF_P_SCN];
  assign edge_s   = sclk_hi & ~sclk_hi_q;
  assign sync_low = ~pin_s_q[SJF_P_SYN];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_hi_q <= 1'b0;
    end else begin
      sclk_hi_q <= sclk_hi;
    end
  end

  // ************************************************************
  // conversion latency pipeline
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pipe_q[0] <= '0;
    end else if (edge_s) begin
      pipe_q[0] <= din_s_q;
    end
  end

  for (genvar i = 1; i < LAT; i++) begin : g_pipe
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        pipe_q[i] <= '0;
      end else if (edge_s) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // ************************************************************
  // sync request and frame state
  // ************************************************************
  assign pre_frame = sync_low && (st_q == TX_SYNC || low_q >= LOW_TRIG);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      low_q <= '0;
    end else if (edge_s) begin
      if (!sync_low) begin
        low_q <= '0;
      end else if (low_q != LOW_MAX) begin
        low_q <= low_q + 2'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q     <= TX_DATA;
      synced_q <= 1'b0;
    end else if (edge_s) begin
      case (st_q)
        TX_DATA: begin
          if (pre_frame) begin
            st_q     <= TX_SYNC;
            synced_q <= 1'b0;
          end
        end
        TX_SYNC: begin
          if (!pre_frame) begin
            st_q     <= TX_DATA;
            synced_q <= 1'b1;
          end
        end
        default: st_q <= TX_DATA;
      endcase
    end
  end

  // ************************************************************
  // scrambler and frame monitor
  // ************************************************************
  assign scr_w   = sjf_scr(pipe_q[LAT-1], scr_q, 1'b0);
  assign word    = pin_s_q[SJF_P_SCR] ? scr_w[15:0] : pipe_q[LAT-1];
  assign fam_hit = pin_s_q[SJF_P_FAM] && synced_q
                   && (word[7:0] == prev_lo_q);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      scr_q     <= SJF_SCR_RST;
      prev_lo_q <= '0;
    end else if (edge_s && !pre_frame) begin
      if (pin_s_q[SJF_P_SCR]) begin
        scr_q <= scr_w[30:16];
      end
      prev_lo_q <= word[7:0];
    end
  end

  // ************************************************************
  // frame emission and 8b/10b coding
  // ************************************************************
  always_comb begin
    emit = edge_s | second_q;
    if (second_q) begin
      enc_oct = idle2_q ? (rd_q ? SJF_D16_2 : SJF_D5_6) : oct2_q;
      enc_k   = idle2_q ? 1'b0 : k2_q;
    end else begin
      enc_oct = pre_frame ? SJF_K28_5 : word[15:8];
      enc_k   = pre_frame;
    end
  end

  assign enc_r = sjf_enc(enc_oct, enc_k, rd_q);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      second_q <= 1'b0;
      idle2_q  <= 1'b0;
      k2_q     <= 1'b0;
      oct2_q   <= '0;
    end else begin
      second_q <= edge_s;
      if (edge_s) begin
        idle2_q <= pre_frame && pin_s_q[SJF_P_IDL];
        k2_q    <= pre_frame || fam_hit;
        oct2_q  <= pre_frame ? SJF_K28_5 :
                   (fam_hit ? SJF_K28_7 : word[7:0]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_q  <= 1'b0;
      cg_q  <= '0;
      cgv_q <= 1'b0;
    end else begin
      cgv_q <= emit;
      if (emit) begin
        cg_q <= enc_r[9:0];
        rd_q <= enc_r[10];
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync_active <= 1'b0;
      link_synced <= 1'b0;
    end else begin
      sync_active <= (st_q == TX_SYNC);
      link_synced <= synced_q;
    end
  end

  assign link.cg       = cg_q;
  assign link.cg_valid = cgv_q;

endmodule

//--- rtl/sjf_pkg.sv
package sjf_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int SJF_OCT_W    = 8;
  localparam int SJF_CG_W     = 10;
  localparam int SJF_SMP_W    = 16;
  localparam int SJF_PIPE_LAT = 9;
  localparam int SJF_SYNC_MIN = 2;
  localparam int SJF_PRE_DET  = 2;
  localparam int SJF_SCR_W    = 15;
  localparam int SJF_TAP_A    = 13;
  localparam int SJF_TAP_B    = 14;

  // ************************************************************
  // pin bundle positions and reset
  // ************************************************************
  localparam int SJF_NPIN  = 6;
  localparam int SJF_P_SCP = 5;
  localparam int SJF_P_SCN = 4;
  localparam int SJF_P_SYN = 3;
  localparam int SJF_P_FAM = 2;
  localparam int SJF_P_SCR = 1;
  localparam int SJF_P_IDL = 0;
  localparam logic [5:0] SJF_PIN_RST = 6'h08;
  localparam logic [14:0] SJF_SCR_RST = 15'h0000;

  // ************************************************************
  // special octets
  // ************************************************************
  localparam logic [7:0] SJF_K28_1 = 8'h3c;
  localparam logic [7:0] SJF_K28_5 = 8'hbc;
  localparam logic [7:0] SJF_K28_7 = 8'hfc;
  localparam logic [7:0] SJF_D16_2 = 8'h50;
  localparam logic [7:0] SJF_D5_6  = 8'hc5;

  // ************************************************************
  // coding tables, negative disparity forms
  // ************************************************************
  localparam logic [5:0] SJF_T6 [0:31] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] SJF_T4 [0:7] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] SJF_K4 [0:7] = '{
    4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
  localparam logic [5:0] SJF_K28_6B = 6'h0f;
  localparam logic [3:0] SJF_A7     = 4'h7;
  localparam logic [3:0] SJF_KX7    = 4'h8;

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [1:0] {
    TX_DATA = 2'b01,
    TX_SYNC = 2'b10
  } sjf_tx_st_e;

  typedef enum logic [2:0] {
    RX_SYNC = 3'b001,
    RX_WAIT = 3'b010,
    RX_DATA = 3'b100
  } sjf_rx_st_e;

  // ************************************************************
  // functions
  // ************************************************************
  // disparity after one sub-block
  function automatic logic sjf_sub_rd(input logic rd,
                                      input logic [5:0] b,
                                      input int n);
    int ones;
    ones = $countones(b);
    if (2 * ones > n) return 1'b1;
    if (2 * ones < n) return 1'b0;
    return rd;
  endfunction

  // returns {rd_out, code_group}; bit 9 goes out first
  function automatic logic [10:0] sjf_enc(input logic [7:0] d,
                                          input logic       k,
                                          input logic       rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd6;
    x  = d[4:0];
    y  = d[7:5];
    s6 = SJF_T6[x];
    s4 = SJF_T4[y];
    if (k) begin
      if (x == 5'd28) begin
        s6 = SJF_K28_6B;
        s4 = SJF_K4[y];
      end else begin
        s4 = SJF_KX7;
      end
      if (rd) begin
        s6 = ~s6;
        s4 = ~s4;
      end
      rd6 = sjf_sub_rd(rd, s6, 6);
    end else begin
      if (rd && ($countones(s6) != 3 || x == 5'd7)) s6 = ~s6;
      rd6 = sjf_sub_rd(rd, s6, 6);
      if (y == 3'd7 && (rd6 ? (x == 5'd11 || x == 5'd13 || x == 5'd14)
                            : (x == 5'd17 || x == 5'd18 || x == 5'd20)))
        s4 = SJF_A7;
      if (rd6 && ($countones(s4) != 2 || y == 3'd3)) s4 = ~s4;
    end
    return {sjf_sub_rd(rd6, {2'b00, s4}, 4), s6, s4};
  endfunction

  // returns {hit, octet} for a data code-group of either polarity
  function automatic logic [8:0] sjf_dec(input logic [9:0] cg);
    logic [10:0] a;
    logic [10:0] b;
    logic [8:0]  r;
    r = '0;
    for (int i = 0; i < 256; i++) begin
      a = sjf_enc(8'(i), 1'b0, 1'b0);
      b = sjf_enc(8'(i), 1'b0, 1'b1);
      if (a[9:0] == cg || b[9:0] == cg) r = {1'b1, 8'(i)};
    end
    return r;
  endfunction

  function automatic logic sjf_is_k(input logic [9:0] cg,
                                    input logic [7:0] oct);
    logic [10:0] a;
    logic [10:0] b;
    a = sjf_enc(oct, 1'b1, 1'b0);
    b = sjf_enc(oct, 1'b1, 1'b1);
    return (a[9:0] == cg) || (b[9:0] == cg);
  endfunction

  // self-synchronous 1 + x^14 + x^15; returns {state, word}
  function automatic logic [30:0] sjf_scr(input logic [15:0] w,
                                          input logic [14:0] st,
                                          input logic        descr);
    logic [14:0] s;
    logic [15:0] o;
    logic        b;
    s = st;
    o = '0;
    for (int i = 15; i >= 0; i--) begin
      b    = w[i] ^ s[SJF_TAP_A] ^ s[SJF_TAP_B];
      o[i] = b;
      s    = {s[13:0], descr ? w[i] : b};
    end
    return {s, o};
  endfunction

endpackage

//--- rtl/sjf_link_if.sv
`timescale 1ns/10ps
interface sjf_link_if;
  import sjf_pkg::*;
  logic [SJF_CG_W-1:0] cg;
  logic                cg_valid;
  logic                sync_n;

  modport dev (
    output cg,
    output cg_valid,
    input  sync_n
  );

  modport rcv (
    input  cg,
    input  cg_valid,
    output sync_n
  );
endinterface

//--- rtl/sjf_rx.sv
`timescale 1ns/10ps
module sjf_rx
  import sjf_pkg::*;
(
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  rstn,
  // user controls
  input wire logic                  resync_req,
  input wire logic                  scramble_enable,
  input wire logic                  frame_monitor_enable,
  // user data and status
  output logic [SJF_SMP_W-1:0]      sample_out,
  output logic                      sample_valid,
  output logic                      link_up,
  output logic                      align_err,
  output logic                      code_err,
  // link
  sjf_link_if.rcv                   link
);

  localparam logic [1:0] PRE_TRIG = 2'(SJF_PRE_DET - 1);

  sjf_rx_st_e  st_q;
  logic        sync_n_q;
  logic [1:0]  kcnt_q;
  logic        ph_q;
  logic [8:0]  dec;
  logic        k5;
  logic        k7;
  logic        v;
  logic        start;
  logic        lost;
  logic [7:0]  lo_w;
  logic [30:0] ds;
  logic [7:0]  hi_q;
  logic [7:0]  prev_lo_q;
  logic        first_q;
  logic [14:0] dscr_q;

  // ************************************************************
  // code-group classification
  // ************************************************************
  assign v     = link.cg_valid;
  assign dec   = sjf_dec(link.cg);
  assign k5    = sjf_is_k(link.cg, SJF_K28_5);
  assign k7    = sjf_is_k(link.cg, SJF_K28_7);
  assign start = v && st_q == RX_WAIT && !ph_q && !k5 && dec[8];
  assign lost  = v && st_q == RX_DATA && (k5 || (k7 && !ph_q));
  assign lo_w  = (k7 && frame_monitor_enable) ? prev_lo_q : dec[7:0];
  assign ds    = sjf_scr({hi_q, lo_w}, dscr_q, 1'b1);

  // ************************************************************
  // sync request and alignment state
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q     <= RX_SYNC;
      sync_n_q <= 1'b0;
      kcnt_q   <= '0;
      ph_q     <= 1'b0;
    end else begin
      if (v) begin
        ph_q <= (st_q == RX_SYNC && kcnt_q == 2'd0 && k5) ? 1'b1 : ~ph_q;
      end
      case (st_q)
        RX_SYNC: begin
          if (v && k5) begin
            if (kcnt_q == PRE_TRIG) begin
              st_q     <= RX_WAIT;
              sync_n_q <= 1'b1;
              kcnt_q   <= '0;
            end else begin
              kcnt_q <= kcnt_q + 2'd1;
            end
          end
        end
        RX_WAIT: if (start) st_q <= RX_DATA;
        RX_DATA: begin
          if (lost) begin
            st_q     <= RX_SYNC;
            sync_n_q <= 1'b0;
          end
        end
        default: st_q <= RX_SYNC;
      endcase
      if (resync_req) begin
        st_q     <= RX_SYNC;
        sync_n_q <= 1'b0;
        kcnt_q   <= '0;
      end
    end
  end

  // ************************************************************
  // frame assembly, marker restore and descrambling
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hi_q         <= '0;
      prev_lo_q    <= '0;
      first_q      <= 1'b0;
      dscr_q       <= SJF_SCR_RST;
      sample_out   <= '0;
      sample_valid <= 1'b0;
      align_err    <= 1'b0;
      code_err     <= 1'b0;
      link_up      <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      align_err    <= lost;
      code_err     <= v && st_q == RX_DATA && !dec[8] && !k5
                      && !(k7 && frame_monitor_enable);
      link_up      <= (st_q == RX_DATA);
      if (start) begin
        hi_q    <= dec[7:0];
        first_q <= 1'b1;
      end else if (v && st_q == RX_DATA && !lost) begin
        if (!ph_q) begin
          hi_q <= dec[7:0];
        end else begin
          prev_lo_q <= lo_w;
          first_q   <= 1'b0;
          if (scramble_enable) begin
            dscr_q <= ds[30:16];
          end
          sample_out   <= scramble_enable ? ds[15:0] : {hi_q, lo_w};
          sample_valid <= !(first_q && scramble_enable);
        end
      end
    end
  end

  assign link.sync_n = sync_n_q;

endmodule

//--- dv/sjf_assertions.sv
`timescale 1ns/10ps
module sjf_assertions
  import sjf_pkg::*;
#(
  parameter int SPAN = 48
) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                rstn,
  // link
  input wire logic [SJF_CG_W-1:0] cg,
  input wire logic                cg_valid,
  input wire logic                sync_n
);
  // ************************************************************
  // frame position and code-group classes
  // ************************************************************
  logic                pos_q;
  logic [SJF_CG_W-1:0] prev_q;
  logic                k285;
  logic                k285_prev;
  logic                k287;
  logic                comma_k;
  logic                idle_d;

  assign k285      = (cg == 10'h0fa) || (cg == 10'h305);
  assign k285_prev = (prev_q == 10'h0fa) || (prev_q == 10'h305);
  assign k287      = (cg == 10'h0f8) || (cg == 10'h307);
  assign comma_k   = k285 || k287 || (cg == 10'h0f9) || (cg == 10'h306);
  assign idle_d    = (cg == 10'h245) || (cg == 10'h296);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pos_q <= 1'b0;
    end else if (cg_valid) begin
      pos_q <= ~pos_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prev_q <= '0;
    end else if (cg_valid) begin
      prev_q <= cg;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ************************************************************
  // checks
  // ************************************************************
  chk_frame_pair: assert property (
    cg_valid && !pos_q |=> cg_valid && pos_q)
    else $error("frame second code-group missing");
  chk_frame_gap: assert property (
    cg_valid && pos_q |=> !cg_valid)
    else $error("frame longer than two code-groups");
  chk_cg_hold: assert property (
    !cg_valid |-> $stable(cg))
    else $error("code-group changed between strobes");
  chk_comma_only_k: assert property (
    cg_valid && (cg[9:3] == 7'h1f || cg[9:3] == 7'h60) |-> comma_k)
    else $error("comma inside a data code-group");
  chk_marker_last: assert property (
    cg_valid && k287 |-> pos_q)
    else $error("marker not in last position");
  chk_preamble_whole: assert property (
    cg_valid && pos_q && k285 |-> k285_prev)
    else $error("preamble frame broken");
  chk_rd_flip: assert property (
    cg_valid && pos_q && k285 && k285_prev |-> cg != prev_q)
    else $error("disparity not followed");
  chk_idle_set: assert property (
    cg_valid && pos_q && idle_d && k285_prev
    |-> cg == ((prev_q == 10'h0fa) ? 10'h245 : 10'h296))
    else $error("idle set ends positive");
  chk_sub_blocks: assert property (
    cg_valid |-> $countones(cg[9:4]) inside {[2:4]}
                 && $countones(cg[3:0]) inside {[1:3]})
    else $error("unbalanced sub-block");
  chk_release_cause: assert property (
    $rose(sync_n) |-> $past(cg_valid) && $past(k285))
    else $error("request withdrawn without preamble");
  chk_sync_answer: assert property (
    $fell(sync_n) |-> ##[1:SPAN] (cg_valid && k285))
    else $error("no preamble after request");
  chk_data_resume: assert property (
    $rose(sync_n) |-> ##[1:SPAN] (cg_valid && !pos_q && !comma_k))
    else $error("no data after request released");
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sjf_pkg::*;

  // ************************************************************
  // signals
  // ************************************************************
  logic                 mclk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 sample_clock_p = 1'b0;
  logic                 sample_clock_n = 1'b1;
  logic [SJF_SMP_W-1:0] sample_in = '0;
  logic                 scr_en = 1'b0;
  logic                 fam_en = 1'b0;
  logic                 idle_sel = 1'b0;
  logic                 fix_lo = 1'b0;
  logic                 resync_req = 1'b0;
  logic                 sync_active;
  logic                 link_synced;
  logic [SJF_SMP_W-1:0] sample_out;
  logic                 sample_valid;
  logic                 link_up;
  logic                 align_err;
  logic                 code_err;
  logic [2:0]           sc_cnt = '0;
  logic [15:0]          rnd;
  logic [SJF_SMP_W-1:0] q[$];
  logic [3:0]           modes [0:3] = '{4'h1, 4'h9, 4'h5, 4'he};
  int                   seed = 32'h981c9af7;
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  int                   n_valid, k287_n, idl_n, err_n, base_n, sa_n;

  always #5 mclk = ~mclk;

  sjf_link_if link ();

  sjf_tx #(.LAT(SJF_PIPE_LAT)) sjf_tx_inst (
    .mclk(mclk), .rstn(rstn),
    .sample_clock_p(sample_clock_p), .sample_clock_n(sample_clock_n),
    .sample_in(sample_in), .scramble_enable(scr_en),
    .frame_monitor_enable(fam_en), .idle_sync_select(idle_sel),
    .sync_active(sync_active), .link_synced(link_synced), .link(link));

  sjf_rx sjf_rx_inst (
    .mclk(mclk), .rstn(rstn), .resync_req(resync_req),
    .scramble_enable(scr_en), .frame_monitor_enable(fam_en),
    .sample_out(sample_out), .sample_valid(sample_valid),
    .link_up(link_up), .align_err(align_err), .code_err(code_err),
    .link(link));

  sjf_assertions sjf_assertions_inst (
    .mclk(mclk), .rstn(rstn), .cg(link.cg),
    .cg_valid(link.cg_valid), .sync_n(link.sync_n));

  // ************************************************************
  // compare tasks and closing report
  // ************************************************************
  task automatic cmp_smp(input logic [SJF_SMP_W-1:0] got,
                         input logic [SJF_SMP_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t sample %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t status %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // sample clock and samples, noted as expected results
  // ************************************************************
  always @(negedge mclk) begin
    sc_cnt <= rstn ? sc_cnt + 3'd1 : 3'd0;
    if (!rstn) begin
      q.delete();
      // conversion pipeline holds zeros after reset
      repeat (SJF_PIPE_LAT) q.push_back('0);
      sample_clock_p <= 1'b0;
      sample_clock_n <= 1'b1;
    end else if (sc_cnt == 3'd3) begin
      sample_clock_p <= 1'b1;
      sample_clock_n <= 1'b0;
      q.push_back(sample_in);
    end else if (sc_cnt == 3'd7) begin
      rnd = 16'($random(seed));
      sample_clock_p <= 1'b0;
      sample_clock_n <= 1'b1;
      sample_in <= {rnd[15:8], fix_lo ? 8'h5a : rnd[7:0]};
    end
  end

  // ************************************************************
  // output and wire monitor
  // ************************************************************
  always @(posedge mclk) begin
    if (rstn) begin
      if (link.cg_valid === 1'b1 && (link.cg == 10'h0f8 ||
                                     link.cg == 10'h307)) k287_n++;
      if (link.cg_valid === 1'b1 && (link.cg == 10'h245 ||
                                     link.cg == 10'h296)) idl_n++;
      if (align_err !== 1'b0 || code_err !== 1'b0) err_n++;
      if (sync_active === 1'b1) sa_n++;
      if (sample_valid === 1'b1) begin
        n_valid++;
        while (q.size() > SJF_PIPE_LAT + 1) void'(q.pop_front());
        if (q.size() == SJF_PIPE_LAT + 1) begin
          cmp_smp(sample_out, q.pop_front());
        end else begin
          cmp_cnt(q.size(), SJF_PIPE_LAT + 1);
        end
      end
    end
  end

  // ************************************************************
  // main sequence: one test per mode set {scr, fam, idle, fixed lo}
  // ************************************************************
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {scr_en, fam_en, idle_sel, fix_lo} <= modes[i];
      rstn <= 1'b0;
      n_valid = 0;
      k287_n = 0;
      idl_n = 0;
      err_n = 0;
      sa_n = 0;
      repeat (16) @(negedge mclk);
      rstn <= 1'b1;
      repeat (300) @(negedge mclk);
      if (i == 3) begin
        resync_req <= 1'b1;
        @(negedge mclk);
        resync_req <= 1'b0;
      end
      repeat (300) @(negedge mclk);
      cmp_bit(link_up, 1'b1);
      cmp_bit(link_synced, 1'b1);
      cmp_bit(sync_active, 1'b0);
      cmp_cnt(err_n, 0);
      cmp_cnt(int'(sa_n > 0), 1);
      cmp_cnt(int'(n_valid > 40), 1);
      if (i == 0) begin
        base_n = n_valid;
        cmp_cnt(k287_n, 0);
      end
      if (i == 1) cmp_cnt(n_valid, base_n - 1);
      if (i == 2) cmp_cnt(int'(k287_n > 10), 1);
      if (i == 3) cmp_cnt(int'(idl_n > 0), 1);
      $display("test %0d done, modes %b", i, modes[i]);
    end
    end_of_test();
  end
endmodule
